//--- sim/csaf_props.sv
// Checker on the readout sequencer's top ports.
// Assumes a bind onto csaf_seq and a single clock domain.
`include "csaf_defines.svh"
module csaf_props
  import csaf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input csaf_mode_type mode_sel,
  input wire logic hclk_36,
  input wire logic start,
  input csaf_drive_type drive,
  input wire logic vsync,
  input wire logic busy,
  input wire logic [11:0] lines_done
);
  timeunit 1ns;
  timeprecision 1ps;
  csaf_mode_type mode_q;
  logic h36_q;
  logic [1:0] vs_q;
  logic [11:0] tgt;
  // ----
  // Frame context, latched as the design should
  // ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= CSAF_MODE_CS1;
      h36_q <= 1'b0;
      vs_q <= 2'h0;
    end else begin
      if (start && !busy) begin
        mode_q <= mode_sel;
        h36_q <= hclk_36;
      end
      if (drive.xfer_hi) begin
        vs_q <= 2'h0;
      end else if (drive.vstep && vs_q != 2'h3) begin
        vs_q <= vs_q + 2'h1;
      end
    end
  end
  always_comb begin
    case (mode_q)
      CSAF_MODE_CS3: tgt = h36_q ? `CSAF_LINES_PR_36 : `CSAF_LINES_PR_28;
      CSAF_MODE_AF1: tgt = h36_q ? `CSAF_LINES_AF1_36 : `CSAF_LINES_AF1_28;
      CSAF_MODE_AF2: tgt = h36_q ? `CSAF_LINES_AF2_36 : `CSAF_LINES_AF2_28;
      default: tgt = h36_q ? `CSAF_LINES_CS_36 : `CSAF_LINES_CS_28;
    endcase
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_frame_start: assert property (start && !busy |=> vsync && busy)
    else $error("frame not started");
  a_start_refused: assert property (busy && start |=> !vsync)
    else $error("start taken while busy");
  a_add_shift: assert property (mode_q == CSAF_MODE_CS2 && drive.xfer_lo |-> vs_q == 2'h2)
    else $error("addition shift count wrong");
  a_cs1_no_lo: assert property (busy && mode_q == CSAF_MODE_CS1 |-> !drive.xfer_lo)
    else $error("low pair moved in mode one");
  a_cs3_no_hi: assert property (busy && mode_q == CSAF_MODE_CS3 |-> !drive.xfer_hi)
    else $error("high pair moved in progressive");
  a_af_pair: assert property (mode_q inside {CSAF_MODE_AF1, CSAF_MODE_AF2} && (drive.xfer_hi || drive.xfer_lo)
    |-> drive.xfer_hi && drive.xfer_lo)
    else $error("focus pairs split");
  a_sweep_no_out: assert property (drive.fast |-> !drive.line_out)
    else $error("line out during sweep");
  a_frame_lines: assert property ($fell(busy) |-> lines_done == tgt)
    else $error("frame line count wrong");
  c_frame: cover property (vsync);
  c_add: cover property (mode_q == CSAF_MODE_CS2 && drive.xfer_lo);
  c_end: cover property ($fell(busy));
endmodule : csaf_props
bind csaf_seq csaf_props i_props (.clk, .rst_n, .mode_sel, .hclk_36, .start, .drive, .vsync, .busy, .lines_done);

//--- sim/csaf_sensor.sv
// Sensor model: counts same-colour sums in the vertical path.
// Assumes the drive strobes come straight from the sequencer.
module csaf_sensor
  import csaf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input csaf_drive_type drive,
  output logic [11:0] sum_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] shift_q;
  logic held_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 2'h0;
      held_q <= 1'b0;
      sum_cnt <= 12'h000;
    end else begin
      if (drive.xfer_hi && !drive.xfer_lo) begin
        held_q <= 1'b1;
        shift_q <= 2'h0;
      end else if (drive.vstep && held_q && shift_q != 2'h3) begin
        shift_q <= shift_q + 2'h1;
      end
      if (drive.xfer_lo && held_q && shift_q == 2'h2) begin
        sum_cnt <= sum_cnt + 12'h001;
        held_q <= 1'b0;
      end
    end
  end
endmodule : csaf_sensor

//--- sim/tb.sv
// Testbench for the readout sequencer.
// Assumes the design, checker and sensor model compile first.
`include "csaf_defines.svh"
module tb
  import csaf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  csaf_mode_type mode_sel = CSAF_MODE_CS1;
  logic hclk_36 = 1'b0;
  logic start = 1'b0;
  csaf_drive_type drive;
  logic vsync;
  logic busy;
  logic [11:0] lines_done;
  logic [11:0] sum_cnt;
  int n_mismatch = 0;
  int checked = 0;
  int n_fast = 0;
  int n_line = 0;
  logic timed_out = 1'b0;
  initial begin
    forever #5 clk = ~clk;
  end
  csaf_seq i_dut (.clk, .rst_n, .mode_sel, .hclk_36, .start, .drive, .vsync, .busy, .lines_done);
  csaf_sensor i_sensor (.clk, .rst_n, .drive, .sum_cnt);
  // Pulses counted on the rising edge, away from the bench's own edge
  always @(posedge clk) begin
    if (rst_n && drive.fast === 1'b1) begin
      n_fast <= n_fast + 1;
    end
    if (rst_n && drive.line_out === 1'b1) begin
      n_line <= n_line + 1;
    end
  end
  task automatic report_and_stop();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // Sel 0 waits for a row transfer, 1 for frame end
  task automatic wait_on(input int sel);
    int i;
    i = 0;
    while (!timed_out && ((sel == 0 ? (drive.xfer_hi | drive.xfer_lo) : !busy) !== 1'b1)) begin
      @(negedge clk);
      i++;
      if (i > 40000) begin
        // A hang is one mismatch; later waits return at once so the verdict comes soon
        n_mismatch++;
        timed_out = 1'b1;
        $display("CHECK FAILED wait_on expected %0d seen timeout", sel);
      end
    end
  endtask : wait_on
  task automatic rst_cycle(input int n);
    rst_n = 1'b0;
    repeat (n) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
  endtask : rst_cycle
  // Answer latency is open by one cycle, so both are watched
  task automatic pulse_start(input csaf_mode_type m, input logic h, input logic exp);
    logic seen;
    mode_sel = m;
    hclk_36 = h;
    start = 1'b1;
    @(negedge clk);
    seen = vsync;
    start = 1'b0;
    @(negedge clk);
    seen = seen | vsync;
    cmp("vsync", {11'h0, exp}, {11'h0, seen});
  endtask : pulse_start
  task automatic t_af2_frame();
    int f0;
    int l0;
    f0 = n_fast;
    l0 = n_line;
    pulse_start(CSAF_MODE_AF2, 1'b0, 1'b1);
    repeat (50) @(negedge clk);
    pulse_start(CSAF_MODE_CS3, 1'b1, 1'b0);
    wait_on(1);
    // Last bottom step stands with busy low; let the counter take it
    @(negedge clk);
    cmp("lines", 12'h02b, lines_done);
    cmp("line_out", `CSAF_LINES_AF2_28, 12'(n_line - l0));
    cmp("fast", `CSAF_SENSOR_ROWS - `CSAF_BAND_AF2, 12'(n_fast - f0));
    $display("test af2_frame done");
  endtask : t_af2_frame
  task automatic t_row_order();
    csaf_mode_type m[4] = '{CSAF_MODE_CS1, CSAF_MODE_CS2, CSAF_MODE_CS3, CSAF_MODE_AF1};
    logic [1:0] e[4] = '{2'b10, 2'b10, 2'b01, 2'b11};
    logic [11:0] top_rows[4] = '{(`CSAF_SENSOR_ROWS - `CSAF_BAND_CS) >> 1, (`CSAF_SENSOR_ROWS - `CSAF_BAND_CS) >> 1,
      (`CSAF_SENSOR_ROWS - `CSAF_LINES_PR_36) >> 1, (`CSAF_SENSOR_ROWS - `CSAF_BAND_AF1) >> 1};
    int f0;
    for (int k = 0; k < 4; k++) begin
      rst_cycle(2);
      cmp("busy", 12'h000, {11'h0, busy});
      f0 = n_fast;
      pulse_start(m[k], 1'b1, 1'b1);
      wait_on(0);
      cmp("xfer", {10'h0, e[k]}, {10'h0, drive.xfer_hi, drive.xfer_lo});
      cmp("top_sweep", top_rows[k], 12'(n_fast - f0));
    end
    $display("test row_order done");
  endtask : t_row_order
  task automatic t_add_order();
    int n;
    n = 0;
    rst_cycle(2);
    pulse_start(CSAF_MODE_CS2, 1'b0, 1'b1);
    wait_on(0);
    for (int i = 0; i < 1000 && drive.xfer_lo !== 1'b1; i++) begin
      n += int'(drive.vstep === 1'b1);
      @(negedge clk);
    end
    cmp("shifts", 12'h002, n[11:0]);
    @(negedge clk);
    cmp("sums", 12'h001, sum_cnt);
    $display("test add_order done");
  endtask : t_add_order
  initial begin
    rst_cycle(12);
    t_af2_frame();
    t_row_order();
    t_add_order();
    report_and_stop();
  end
endmodule : tb

//--- src/csaf_defines.svh
// Timing and geometry constants for the center-scan / focus readout sequencer.
// Assumes inclusion by bare name from design and sim files.
`ifndef CSAF_DEFINES_SVH
`define CSAF_DEFINES_SVH
`define CSAF_CLK_MHZ 100
`define CSAF_SENSOR_ROWS 12'h4e0
`define CSAF_BAND_CS 12'h470
`define CSAF_BAND_AF1 12'h3ac
`define CSAF_BAND_AF2 12'h12c
`define CSAF_LINES_CS_36 12'h238
`define CSAF_LINES_CS_28 12'h1b2
`define CSAF_LINES_PR_36 12'h244
`define CSAF_LINES_PR_28 12'h1bc
`define CSAF_LINES_AF1_36 12'h0eb
`define CSAF_LINES_AF1_28 12'h0aa
`define CSAF_LINES_AF2_36 12'h04b
`define CSAF_LINES_AF2_28 12'h02b
`define CSAF_ADD_SHIFT 12'h002
`define CSAF_VSTEP_DIV 8'h08
`define CSAF_LINE_CYC 16'h0100
`endif

//--- src/csaf_div.sv
// Enable divider: one-cycle pulse every DIV clocks.
// Assumes a single clock domain.
module csaf_div
  import csaf_pkg::*;
#(
  parameter logic [7:0] DIV = 8'h08
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  csaf_div_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.cnt == DIV - 8'h01) begin
      s_d.cnt = 8'h00;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = (s_q.cnt == DIV - 8'h01);
endmodule : csaf_div

//--- src/csaf_pkg.sv
// Types for the center-scan / focus readout sequencer.
// Assumes no surroundings beyond the design files.
package csaf_pkg;
  typedef enum logic [2:0] {
    CSAF_MODE_CS1,
    CSAF_MODE_CS2,
    CSAF_MODE_CS3,
    CSAF_MODE_AF1,
    CSAF_MODE_AF2
  } csaf_mode_type;

  typedef struct packed {
    logic vstep;
    logic fast;
    logic xfer_hi;
    logic xfer_lo;
    logic line_out;
  } csaf_drive_type;

  typedef struct packed {
    logic [7:0] cnt;
  } csaf_div_state_type;
endpackage : csaf_pkg

//--- src/csaf_seq.sv
// Frame sequencer driving an interline sensor in center-scan and focus modes.
// Assumes an analog clock driver turns the drive strobes into transfer clocks.
`include "csaf_defines.svh"

// What this block does
// [R1] In the addition mode rows 3-4 of each group of four move first, then two shifts, then rows 1-2.
// [R2] The sensor adds the second row pair into the shifted register; the sequencer only orders it.
// [R3] Two-of-four modes sweep away everything outside a central 1136-row band.
// [R4] The addition mode outputs 568 lines at 36MHz and 434 at 28.6364MHz.
// [R5] The progressive center mode reads every row after sweeping the outside rows.
// [R6] The progressive center mode outputs 580 lines at 36MHz and 444 at 28.6364MHz.
// [R7] Focus mode one keeps a 940-row band and reads the first and sixth of each eight.
// [R8] Focus mode one outputs 235 lines at 36MHz and 170 at 28.6364MHz.
// [R9] Focus mode two keeps a 300-row band, reads two of eight, outputs 75 or 43 lines.
// [R10] Center mode one reads rows 3-4 of each four without addition.
// [R11] Both focus modes use the two-of-eight row choice.
// [R12] Rows outside the band are flushed with fast transfers, not output.
// [R13] Frame periods follow the mode and clock rate, set by the fixed CSAF_LINE_CYC line period.
// [R14] The mode is latched and changed only at a frame boundary.
module csaf_seq
  import csaf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input csaf_mode_type mode_sel,
  input wire logic hclk_36,
  input wire logic start,
  output csaf_drive_type drive,
  output logic vsync,
  output logic busy,
  output logic [11:0] lines_done
);
  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SWEEP_TOP, ST_READ, ST_STEP, ST_SWEEP_BOT
  } csaf_state_type;

  typedef struct packed {
    csaf_state_type st;
    csaf_mode_type mode;
    logic r36;
    logic [11:0] row;
    logic [11:0] band_end;
    logic [11:0] lines;
    logic [11:0] target;
    logic [2:0] phase;
    logic [15:0] wait_cnt;
    csaf_drive_type drv;
    logic vs;
  } csaf_seq_state_type;

  csaf_seq_state_type s_q, s_d;
  logic fast_tick;
  logic [11:0] band;
  logic [11:0] lines_tgt;
  logic [11:0] top;
  // Phase counter only needs to reach the shift count plus one
  localparam logic [2:0] ADD_SHIFT = 3'(`CSAF_ADD_SHIFT);

  // ---------------------------------------------------------------
  // Row step divider
  // ---------------------------------------------------------------
  // Free running, so the first sweep step may land up to one period late
  csaf_div #(.DIV(`CSAF_VSTEP_DIV)) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .tick(fast_tick)
  );

  // ---------------------------------------------------------------
  // Band and line counts per mode
  // ---------------------------------------------------------------
  always_comb begin
    band = `CSAF_BAND_CS;
    lines_tgt = `CSAF_LINES_CS_28;
    unique case (mode_sel)
      // [R3] central band for two-of-four
      CSAF_MODE_CS1, CSAF_MODE_CS2: begin
        band = `CSAF_BAND_CS;
        // [R4] addition line count
        lines_tgt = hclk_36 ? `CSAF_LINES_CS_36 : `CSAF_LINES_CS_28;
      end
      CSAF_MODE_CS3: begin
        // Band derived from line count since progressive reads one row per line
        band = hclk_36 ? `CSAF_LINES_PR_36 : `CSAF_LINES_PR_28;
        // [R6] progressive line count
        lines_tgt = hclk_36 ? `CSAF_LINES_PR_36 : `CSAF_LINES_PR_28;
      end
      CSAF_MODE_AF1: begin
        // [R7] 940-row band
        band = `CSAF_BAND_AF1;
        // [R8] focus one line count
        lines_tgt = hclk_36 ? `CSAF_LINES_AF1_36 : `CSAF_LINES_AF1_28;
      end
      CSAF_MODE_AF2: begin
        band = `CSAF_BAND_AF2;
        // [R9] focus two line count
        lines_tgt = hclk_36 ? `CSAF_LINES_AF2_36 : `CSAF_LINES_AF2_28;
      end
      // Unused codes fall back to the central band
      default: begin
      end
    endcase
    // Odd leftover row goes to the bottom sweep
    top = (`CSAF_SENSOR_ROWS - band) >> 1;
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.drv = '0;
    s_d.vs = 1'b0;
    unique case (s_q.st)
      ST_IDLE: begin
        // Start is only looked at here, never mid-frame
        if (start) begin
          // [R14] mode latched at frame start
          s_d.mode = mode_sel;
          s_d.r36 = hclk_36;
          s_d.target = lines_tgt;
          s_d.band_end = top + band;
          s_d.row = top;
          s_d.lines = 12'h000;
          s_d.phase = 3'h0;
          s_d.vs = 1'b1;
          s_d.st = ST_SWEEP_TOP;
        end
      end
      ST_SWEEP_TOP: begin
        // [R12] fast flush of top rows
        if (fast_tick) begin
          s_d.drv.fast = 1'b1;
          s_d.drv.vstep = 1'b1;
          if (s_q.row == 12'h000 || s_q.row == 12'h001) begin
            s_d.st = ST_READ;
            s_d.wait_cnt = 16'h0000;
          end
          s_d.row = s_q.row - 12'h001;
        end
      end
      ST_READ: begin
        // One line period per output line; line period sets the frame rate
        // [R13] line period paces frame rate
        if (s_q.wait_cnt == 16'h0000) begin
          unique case (s_q.mode)
            // [R1] rows 3-4 first, then two shifts, then 1-2
            CSAF_MODE_CS2: begin
              s_d.drv.xfer_hi = 1'b1;
              s_d.phase = 3'h1;
            end
            // [R10] rows 3-4 only
            CSAF_MODE_CS1: s_d.drv.xfer_hi = 1'b1;
            // [R11] first and sixth of eight
            CSAF_MODE_AF1, CSAF_MODE_AF2: begin
              s_d.drv.xfer_hi = 1'b1;
              s_d.drv.xfer_lo = 1'b1;
            end
            // [R5] every row progressively
            CSAF_MODE_CS3: s_d.drv.xfer_lo = 1'b1;
            // Unknown latched mode moves no rows
            default: s_d.drv = '0;
          endcase
          s_d.wait_cnt = 16'h0001;
        end else if (s_q.phase != 3'h0 && s_q.phase <= ADD_SHIFT) begin
          s_d.drv.vstep = 1'b1;
          s_d.phase = s_q.phase + 3'h1;
        end else if (s_q.phase == ADD_SHIFT + 3'h1) begin
          // [R2] second pair summed in shifted register
          s_d.drv.xfer_lo = 1'b1;
          s_d.phase = 3'h0;
        end else if (s_q.wait_cnt == `CSAF_LINE_CYC) begin
          s_d.drv.line_out = 1'b1;
          s_d.lines = s_q.lines + 12'h001;
          s_d.wait_cnt = 16'h0000;
          if (s_q.lines + 12'h001 == s_q.target) begin
            s_d.st = ST_SWEEP_BOT;
            s_d.row = s_q.band_end;
          end
        end else begin
          s_d.wait_cnt = s_q.wait_cnt + 16'h0001;
        end
      end
      ST_STEP: s_d.st = ST_READ;
      ST_SWEEP_BOT: begin
        // [R12] fast flush of bottom rows
        if (fast_tick) begin
          s_d.drv.fast = 1'b1;
          s_d.drv.vstep = 1'b1;
          s_d.row = s_q.row + 12'h001;
          // Last step is the bottom row; busy drops with it
          if (s_q.row >= `CSAF_SENSOR_ROWS - 12'h001) begin
            s_d.st = ST_IDLE;
          end
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign drive = s_q.drv;
  assign vsync = s_q.vs;
  // Busy covers both sweeps so a new start waits for the flush
  assign busy = (s_q.st != ST_IDLE);
  assign lines_done = s_q.lines;
endmodule : csaf_seq
